// ---- hw/transceiver_register_interface.sv ----
// Transceiver register bank: data port, command, mode, status, errors
`timescale 1ns/1ns
`include "rti_map.svh"
module transceiver_register_interface (
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     cfg_rst,
    input  wire logic [2:0]               reg_addr,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [7:0]               reg_wdata,
    output logic [7:0]                    reg_rdata,
    output logic                          tx_word_valid,
    input  wire logic                     tx_word_ready,
    output logic [`RTI_TX_WIDTH-1:0]      tx_word_data,
    input  wire logic                     rx_word_valid,
    output logic                          rx_word_ready,
    input  wire logic [`RTI_RX_WIDTH-1:0] rx_word_data,
    input  wire logic                     rx_err_parity,
    input  wire logic                     rx_err_ending,
    input  wire logic                     rx_err_midbit,
    input  wire logic                     rx_start,
    input  wire logic                     rx_end,
    input  wire logic                     line_activity,
    input  wire logic                     tx_pre_start,
    input  wire logic                     tx_sending,
    input  wire logic                     tx_serial_raw,
    input  wire logic                     serial_din,
    input  wire logic                     comparator_in,
    output logic                          tx_serial_out,
    output logic                          rx_serial,
    output logic                          tx_active_pin,
    output logic                          rx_allow,
    output logic [1:0]                    quiesce_bits,
    output rti_pkg::proto_t               protocol_sel,
    output logic                          xcvr_reset,
    output logic                          rx_full_bit,
    output logic                          tx_empty_bit
);
    // ======================================================================
    // Declarations
    logic [7:0]                    cmd;
    logic [7:0]                    next_cmd;
    logic [7:0]                    mode;
    logic [7:0]                    next_mode;
    logic                          eview;
    logic                          clr;
    logic                          loop;
    logic                          wr_port;
    logic                          rd_port;
    logic                          rd_ecr;
    logic                          tx_room;
    logic [1:0]                    tx_level;
    logic                          tx_push;
    logic                          rx_avail;
    logic [1:0]                    rx_level;
    logic [`RTI_RX_WIDTH-1:0]      rx_head;
    logic                          rx_push;
    logic [`RTI_ERR_BITS-1:0]      ecr_set;
    logic [`RTI_ERR_BITS-1:0]      error_code_register;
    logic                          err_evt;
    logic                          rx_fault;
    logic                          ta_flag;
    logic                          next_ta;
    logic                          ra;
    logic                          next_ra;
    logic                          word_present_bit;
    logic                          next_dav;
    logic [7:0]                    sts;
    logic [7:0]                    next_rdata;
    logic                          next_txpin;
    logic                          next_txser;
    logic                          next_rxser;

    // ======================================================================
    // Decode of the four register locations
    assign eview   = cmd[`RTI_CMD_EVIEW];
    assign clr     = mode[`RTI_MODE_SRST];
    assign loop    = mode[`RTI_MODE_LOOP];
    assign wr_port = reg_wr & (reg_addr == `RTI_ADR_PORT) & !eview;
    assign rd_port = reg_rd & (reg_addr == `RTI_ADR_PORT) & !eview;
    assign rd_ecr  = reg_rd & (reg_addr == `RTI_ADR_PORT) & eview;

    // Command and mode registers; the soft reset bit lives on the
    // configuration reset so the chip reset cannot disturb it
    always_comb begin
        next_cmd  = cmd;
        next_mode = mode;
        if (reg_wr && reg_addr == `RTI_ADR_CMD) begin
            next_cmd = reg_wdata;
        end
        if (reg_wr && reg_addr == `RTI_ADR_MODE) begin
            next_mode = reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge cfg_rst) begin
        if (cfg_rst) begin
            cmd  <= `RTI_CMD_RST;
            mode <= `RTI_MODE_RST;
        end else begin
            cmd  <= next_cmd;
            mode <= next_mode;
        end
    end

    // ======================================================================
    // Transmit FIFO: parity sense rides along with each word
    assign tx_push = wr_port & !clr;

    word_fifo #(
        .WIDTH (`RTI_TX_WIDTH),
        .DEPTH (`RTI_FIFO_DEPTH)
    ) tx_fifo (
        .clk       (sys_clk),
        .rst       (sys_rst),
        .clr       (clr),
        .in_valid  (tx_push),
        .in_ready  (tx_room),
        .in_data   ({cmd[`RTI_CMD_PAR],
                     cmd[`RTI_CMD_UP_HI:`RTI_CMD_UP_LO],
                     reg_wdata}),
        .out_valid (tx_word_valid),
        .out_ready (tx_word_ready),
        .out_data  (tx_word_data),
        .level     (tx_level)
    );

    // ======================================================================
    // Receive FIFO: the decoder cannot stall, so a word that meets a full
    // FIFO is dropped and flagged as overrun
    assign rx_push = rx_word_valid & !clr;

    word_fifo #(
        .WIDTH (`RTI_RX_WIDTH),
        .DEPTH (`RTI_FIFO_DEPTH)
    ) rx_fifo (
        .clk       (sys_clk),
        .rst       (sys_rst),
        .clr       (clr),
        .in_valid  (rx_push),
        .in_ready  (rx_word_ready),
        .in_data   (rx_word_data),
        .out_valid (rx_avail),
        .out_ready (rd_port),
        .out_data  (rx_head),
        .level     (rx_level)
    );

    // ======================================================================
    // Error code flags
    assign ecr_set[`RTI_ERR_OVR] = rx_push & !rx_word_ready;
    assign ecr_set[`RTI_ERR_PAR] = rx_err_parity;
    assign ecr_set[`RTI_ERR_END] = rx_err_ending;
    assign ecr_set[`RTI_ERR_MID] = rx_err_midbit;
    assign ecr_set[`RTI_ERR_PRE] = next_ta & !ta_flag & ra
                                 & !mode[`RTI_MODE_RPT];
    assign err_evt  = |ecr_set;
    assign rx_fault = |error_code_register;

    // One sticky flag per error code; soft reset or an error read clears
    for (genvar g = 0; g < `RTI_ERR_BITS; g++) begin : g_err
        sticky_flag err_flag (
            .clk  (sys_clk),
            .rst  (sys_rst),
            .clr  (clr),
            .set  (ecr_set[g] & !clr),
            .take (rd_ecr),
            .flag (error_code_register[g])
        );
    end

    // Status byte: full, sending, fault, in message, present, upper bits
    assign sts = {!tx_room, ta_flag, rx_fault, ra, word_present_bit,
                  rx_head[`RTI_RX_WIDTH-1:8]};

    // ======================================================================
    // Transceiver state, serial routing and read data
    always_comb begin
        logic twx;
        twx = mode[`RTI_MODE_PR_HI:`RTI_MODE_PR_LO] == rti_pkg::proto_twx
           || mode[`RTI_MODE_PR_HI:`RTI_MODE_PR_LO] == rti_pkg::proto_twx_all;
        // Early mode raises the active level during the half-bit lead-in
        next_ta = tx_sending | (cmd[`RTI_CMD_EARLY] & tx_pre_start);
        next_txpin = next_ta & !loop & !clr;
        // Start sets; end, error or idle twinax line clears; set wins
        next_ra = ra;
        if (rx_end || err_evt || (twx && !line_activity)) begin
            next_ra = 1'b0;
        end
        if (rx_start) begin
            next_ra = 1'b1;
        end
        // Present follows the FIFO; an error hides it until new data
        next_dav = word_present_bit;
        if (rd_port || err_evt) begin
            next_dav = 1'b0;
        end
        if ((rd_port && rx_level > 2'h1) || (rx_push && rx_word_ready)) begin
            next_dav = 1'b1;
        end
        if (clr) begin
            next_ta  = 1'b0;
            next_ra  = 1'b0;
            next_dav = 1'b0;
        end
        next_txser = tx_serial_raw ^ mode[`RTI_MODE_TXINV];
        // Loopback feeds the transmitted stream into the receive path
        next_rxser = (loop ? next_txser
                    : (cmd[`RTI_CMD_LSEL] ? comparator_in
                       : serial_din)) ^ mode[`RTI_MODE_RXINV];
        next_rdata = reg_rdata;
        if (reg_rd) begin
            unique case (reg_addr)
                `RTI_ADR_PORT:   next_rdata = eview
                    ? {{(8 - `RTI_ERR_BITS){1'b0}}, error_code_register}
                    : rx_head[7:0];
                `RTI_ADR_STATUS: next_rdata = sts;
                `RTI_ADR_CMD:    next_rdata = cmd;
                `RTI_ADR_MODE:   next_rdata = mode;
                default:         next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ta_flag       <= 1'b0;
            ra            <= 1'b0;
            word_present_bit           <= 1'b0;
            reg_rdata     <= 8'h00;
            tx_active_pin <= 1'b0;
            tx_serial_out <= 1'b0;
            rx_serial     <= 1'b0;
            rx_allow      <= 1'b1;
            quiesce_bits  <= `RTI_QUIESCE_LO;
            protocol_sel  <= rti_pkg::proto_coax;
            xcvr_reset    <= 1'b0;
            rx_full_bit   <= 1'b0;
            tx_empty_bit  <= 1'b1;
        end else begin
            ta_flag       <= next_ta;
            ra            <= next_ra;
            word_present_bit           <= next_dav;
            reg_rdata     <= next_rdata;
            tx_active_pin <= next_txpin;
            tx_serial_out <= next_txser;
            rx_serial     <= next_rxser;
            rx_allow      <= mode[`RTI_MODE_RPT] | !next_ta;
            quiesce_bits  <= cmd[`RTI_CMD_QCNT] ? `RTI_QUIESCE_HI
                                                : `RTI_QUIESCE_LO;
            protocol_sel  <= rti_pkg::proto_t'(
                mode[`RTI_MODE_PR_HI:`RTI_MODE_PR_LO]);
            xcvr_reset    <= clr;
            rx_full_bit   <= rx_level == `RTI_FIFO_FULL;
            tx_empty_bit  <= tx_level == 2'h0;
        end
    end

    // ======================================================================
    // Assertions
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst || cfg_rst || clr);

    push_word_a: assert property (tx_push && tx_level == 2'h0
        |=> tx_word_valid && tx_word_data == $past({cmd[`RTI_CMD_PAR],
            cmd[`RTI_CMD_UP_HI:`RTI_CMD_UP_LO], reg_wdata}))
        else $error("port write did not push the word");
    pop_word_a: assert property (rd_port && rx_avail && !rx_push
        |=> reg_rdata == $past(rx_head[7:0])
            && rx_level == $past(rx_level) - 2'h1)
        else $error("port read did not pop the receive head");
    quiesce_a: assert property (##1 quiesce_bits == ($past(cmd[7])
        ? `RTI_QUIESCE_HI : `RTI_QUIESCE_LO))
        else $error("quiesce count does not follow its select");
    ecr_view_a: assert property (rd_ecr
        |=> reg_rdata == {3'h0, $past(error_code_register)})
        else $error("error view did not return error codes");
    rx_source_a: assert property (!loop && !cmd[`RTI_CMD_LSEL]
        |=> rx_serial == $past(serial_din ^ mode[`RTI_MODE_RXINV]))
        else $error("receive input not taken from the pin");
    early_a: assert property (cmd[`RTI_CMD_EARLY] && tx_pre_start
        && !loop |=> tx_active_pin)
        else $error("active pin not advanced");
    loop_low_a: assert property (loop |=> !tx_active_pin)
        else $error("active pin not held low in loopback");
    tx_full_a: assert property (tx_push && tx_level == 2'h2
        && !tx_word_ready |=> sts[7] ##1 (sts[7] || $past(tx_word_ready)))
        else $error("transmit full not raised");
    ta_status_a: assert property (loop && tx_sending
        |=> ta_flag && !tx_active_pin)
        else $error("sending status masked by loopback");
    fault_a: assert property (err_evt |=> rx_fault && !word_present_bit)
        else $error("receive error not flagged");
    preempt_a: assert property (!ta_flag && tx_sending && ra
        && !mode[`RTI_MODE_RPT] |=> error_code_register[`RTI_ERR_PRE])
        else $error("preempt error not set");
    // A port read in the overrun cycle still pops one word
    overrun_a: assert property (rx_push
        && rx_level == `RTI_FIFO_FULL |=> error_code_register[`RTI_ERR_OVR]
        && (rx_level == `RTI_FIFO_FULL || $past(rd_port)))
        else $error("overrun not flagged");
    rx_full_a: assert property (rx_level == `RTI_FIFO_FULL
        |=> rx_full_bit)
        else $error("receive full flag missing");
    repeat_a: assert property (mode[`RTI_MODE_RPT]
        |=> rx_allow)
        else $error("receiver blocked despite repeat allow");
    in_msg_a: assert property (rx_start |=> ra)
        else $error("in-message bit not set on start");
    tx_empty_a: assert property (tx_level == 2'h0
        |=> tx_empty_bit)
        else $error("transmit empty flag missing");

    fill_tx_c: cover property (tx_push ##2 tx_push ##2 tx_push ##1 !tx_room);
    preempt_c: cover property (ra ##1 error_code_register[`RTI_ERR_PRE]);
    read_word_c: cover property (rx_push ##[1:4] rd_port);
    overrun_c: cover property (ecr_set[`RTI_ERR_OVR] ##[1:8] rd_ecr);
endmodule // transceiver_register_interface

// ---- common/rti_map.svh ----
// Register offsets, field positions, reset values and sizes of the block
`ifndef RTI_MAP_SVH
`define RTI_MAP_SVH
// ==========================================================================
// Register offsets within the alternate register space
`define RTI_ADR_PORT      3'h4
`define RTI_ADR_STATUS    3'h5
`define RTI_ADR_CMD       3'h6
`define RTI_ADR_MODE      3'h7
// ==========================================================================
// Command register fields
`define RTI_CMD_QCNT      7
`define RTI_CMD_EVIEW     6
`define RTI_CMD_LSEL      5
`define RTI_CMD_EARLY     4
`define RTI_CMD_PAR       3
`define RTI_CMD_UP_HI     2
`define RTI_CMD_UP_LO     0
// ==========================================================================
// Mode register fields
`define RTI_MODE_SRST     7
`define RTI_MODE_LOOP     6
`define RTI_MODE_RPT      5
`define RTI_MODE_RXINV    4
`define RTI_MODE_TXINV    3
`define RTI_MODE_PR_HI    2
`define RTI_MODE_PR_LO    0
// ==========================================================================
// Error code register fields
`define RTI_ERR_OVR       4
`define RTI_ERR_PAR       3
`define RTI_ERR_END       2
`define RTI_ERR_MID       1
`define RTI_ERR_PRE       0
`define RTI_ERR_BITS      5
// ==========================================================================
// Reset values and sizes
`define RTI_CMD_RST       8'h00
`define RTI_MODE_RST      8'h00
`define RTI_FIFO_DEPTH    3
`define RTI_FIFO_FULL     2'h3
`define RTI_TX_WIDTH      12
`define RTI_RX_WIDTH      11
`define RTI_QUIESCE_LO    2'h2
`define RTI_QUIESCE_HI    2'h3
`endif

// ---- common/rti_pkg.sv ----
// Types shared by the transceiver register interface
package rti_pkg;
    // ======================================================================
    // Protocol selection shared by transmitter and receiver
    typedef enum logic [2:0] {
        proto_coax      = 3'h0,
        proto_mux       = 3'h1,
        proto_ctrl      = 3'h2,
        proto_rpt       = 3'h3,
        proto_twx       = 3'h4,
        proto_twx_all   = 3'h5,
        proto_byte      = 3'h6,
        proto_byte_all  = 3'h7
    } proto_t;
endpackage

// ---- hw/word_fifo.sv ----
// Shift-style word FIFO whose head word sits in a register
`timescale 1ns/1ns
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 3,
    localparam int LW   = $clog2(DEPTH + 1)
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clr,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [LW-1:0]         level
);
    // ======================================================================
    // Storage
    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [LW-1:0]    cnt;
    logic [LW-1:0]    next_cnt;
    logic             next_in_ready;
    logic             next_out_valid;

    // Words shift down on a pop so the head is always slot zero
    always_comb begin
        logic          push;
        logic          pop;
        logic [LW-1:0] wpos;
        push = in_valid & in_ready;
        pop  = out_ready & out_valid;
        next_mem = mem;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_mem[i] = mem[i + 1];
            end
        end
        wpos = pop ? cnt - LW'(1) : cnt;
        if (push) begin
            next_mem[wpos] = in_data;
        end
        next_cnt = cnt + LW'(push) - LW'(pop);
        if (clr) begin
            next_cnt = '0;
        end
        // Full refuses a push even with a pop pending: no ready loop
        next_in_ready  = next_cnt != LW'(DEPTH);
        next_out_valid = next_cnt != '0;
    end

    // Registering only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            cnt       <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            mem       <= next_mem;
            cnt       <= next_cnt;
            in_ready  <= next_in_ready;
            out_valid <= next_out_valid;
        end
    end

    assign out_data = mem[0];
    assign level    = cnt;
endmodule // word_fifo

// ---- hw/sticky_flag.sv ----
// Sticky error flag: hardware set wins over a read clear
`timescale 1ns/1ns
module sticky_flag (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic clr,
    input  wire logic set,
    input  wire logic take,
    output logic      flag
);
    logic next_flag;

    // Soft reset holds it low; otherwise a set in a clearing cycle sticks
    always_comb begin
        next_flag = !clr & (set | (flag & !take));
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule // sticky_flag

// ---- sim/xcvr_side_model.sv ----
// Encoder sink and decoder source facing the register block
`timescale 1ns/1ns
module xcvr_side_model (
    input  wire logic        sys_clk,
    input  wire logic        stall,
    input  wire logic        send,
    input  wire logic [10:0] word,
    input  wire logic        tx_word_valid,
    input  wire logic [11:0] tx_word_data,
    output logic             tx_word_ready,
    output logic             rx_word_valid,
    output logic [10:0]      rx_word_data,
    output logic [11:0]      last_taken
);
    // Sink stalls on demand; off-pulse data is inverted so stale use shows
    assign tx_word_ready = !stall;
    assign rx_word_valid = send;
    assign rx_word_data  = send ? word : ~word;
    initial last_taken = 12'h000;
    always @(posedge sys_clk) begin
        if (tx_word_valid && tx_word_ready) last_taken <= tx_word_data;
    end
endmodule // xcvr_side_model

// ---- sim/transceiver_register_interface_tb_top.sv ----
// Self-checking bench of the transceiver register interface
`timescale 1ns/1ns
module transceiver_register_interface_tb_top;
    // ==================================================================
    // Signals
    logic sys_clk, sys_rst, cfg_rst, reg_wr, reg_rd, stall, send;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_val;
    logic [10:0] word, rx_word_data;
    logic [11:0] tx_word_data, last_taken;
    logic tx_word_valid, tx_word_ready, rx_word_valid, rx_word_ready;
    logic rx_err_parity, rx_err_ending, rx_err_midbit, rx_start, rx_end;
    logic line_activity, tx_pre_start, tx_sending, tx_serial_raw;
    logic serial_din, comparator_in, tx_serial_out, rx_serial;
    logic tx_active_pin, rx_allow, xcvr_reset, rx_full_bit, tx_empty_bit;
    logic [1:0] quiesce_bits;
    rti_pkg::proto_t protocol_sel;
    int err_count, checked, cycles;
    transceiver_register_interface transceiver_register_interface_inst (
        .sys_clk, .sys_rst, .cfg_rst, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .tx_word_valid, .tx_word_ready,
        .tx_word_data, .rx_word_valid, .rx_word_ready, .rx_word_data,
        .rx_err_parity, .rx_err_ending, .rx_err_midbit, .rx_start, .rx_end,
        .line_activity, .tx_pre_start, .tx_sending, .tx_serial_raw,
        .serial_din, .comparator_in, .tx_serial_out, .rx_serial,
        .tx_active_pin, .rx_allow, .quiesce_bits, .protocol_sel,
        .xcvr_reset, .rx_full_bit, .tx_empty_bit);
    xcvr_side_model xcvr_side_model_inst (.sys_clk, .stall, .send, .word,
        .tx_word_valid, .tx_word_data, .tx_word_ready, .rx_word_valid,
        .rx_word_data, .last_taken);
    // ==================================================================
    // Clock and hang guard; the run needs well under a thousand cycles
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            print_verdict();
        end
    end
    // ==================================================================
    // Shared tasks
    task automatic print_verdict();
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [11:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // One strobe cycle; read data is taken once the answering edge passed
    task automatic acc(input logic wr, input logic [2:0] a,
                       input logic [7:0] d);
        tick(1);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
        tick(1);
        {reg_wr, reg_rd} = 2'b00;
        rd_val = reg_rdata;
    endtask
    // ==================================================================
    // Scenarios
    task automatic t_tx();
        stall = 1;
        acc(1, 3'h6, 8'h0d);
        // Three words fill the FIFO; no write while it is full
        for (int i = 0; i < 3; i++) acc(1, 3'h4, 8'ha5 + 8'(i));
        chk("head", tx_word_data, 12'hda5);
        chk("tx empty", 12'(tx_empty_bit), 12'h000);
        acc(0, 3'h5, 8'h00);
        chk("tx full", 12'(rd_val[7]), 12'h001);
        stall = 0;
        tick(6);
        chk("last sent", last_taken, 12'hda7);
        chk("tx empty", 12'(tx_empty_bit), 12'h001);
    endtask
    task automatic t_rx();
        for (int i = 0; i < 4; i++) begin
            tick(1);
            {send, word} = {1'b1, 3'(i + 1), 8'h30 + 8'(i)};
            tick(1);
            send = 0;
            if (i == 2) begin
                tick(3);
                chk("rx full", 12'(rx_full_bit), 12'h001);
                acc(0, 3'h5, 8'h00);
                chk("status", 12'(rd_val[3:0]), 12'h009);
            end
        end
        acc(0, 3'h5, 8'h00);
        chk("fault", 12'(rd_val[5]), 12'h001);
        chk("present", 12'(rd_val[3]), 12'h000);
        acc(1, 3'h6, 8'h40);
        acc(0, 3'h4, 8'h00);
        chk("overrun", 12'(rd_val[4]), 12'h001);
        acc(0, 3'h4, 8'h00);
        chk("overrun", 12'(rd_val[4]), 12'h000);
        acc(1, 3'h6, 8'h00);
        for (int i = 0; i < 3; i++) begin
            acc(0, 3'h4, 8'h00);
            chk("rx byte", 12'(rd_val), 12'h030 + 12'(i));
        end
        acc(0, 3'h5, 8'h00);
        chk("present", 12'(rd_val[3]), 12'h000);
        chk("rx full", 12'(rx_full_bit), 12'h000);
    endtask
    // Active pin, loopback, repeat, inversion, in-message and preempt
    task automatic t_link();
        tx_pre_start = 1;
        tick(2);
        chk("active", 12'(tx_active_pin), 12'h000);
        acc(1, 3'h6, 8'h10);
        tick(1);
        chk("active", 12'(tx_active_pin), 12'h001);
        {tx_pre_start, tx_sending, tx_serial_raw} = 3'b011;
        acc(1, 3'h7, 8'h40);
        tick(1);
        chk("active", 12'(tx_active_pin), 12'h000);
        chk("looped", 12'(rx_serial), 12'h001);
        chk("rx allow", 12'(rx_allow), 12'h000);
        acc(0, 3'h5, 8'h00);
        chk("sending", 12'(rd_val[6]), 12'h001);
        acc(1, 3'h7, 8'h70);
        tick(1);
        chk("rx invert", 12'(rx_serial), 12'h000);
        chk("rx allow", 12'(rx_allow), 12'h001);
        tx_sending = 0;
        acc(1, 3'h7, 8'h00);
        rx_start = 1;
        tick(1);
        rx_start = 0;
        acc(0, 3'h5, 8'h00);
        chk("in message", 12'(rd_val[4]), 12'h001);
        tx_sending = 1;
        acc(0, 3'h5, 8'h00);
        chk("in message", 12'(rd_val[4]), 12'h000);
        acc(1, 3'h6, 8'h40);
        acc(0, 3'h4, 8'h00);
        chk("preempt", 12'(rd_val[0]), 12'h001);
        {tx_sending, line_activity} = 2'b01;
        acc(1, 3'h7, 8'h04);
        rx_start = 1;
        tick(1);
        rx_start = 0;
        acc(0, 3'h5, 8'h00);
        chk("in message", 12'(rd_val[4]), 12'h001);
        line_activity = 0;
        acc(0, 3'h5, 8'h00);
        chk("in message", 12'(rd_val[4]), 12'h000);
    endtask
    task automatic t_mode();
        {comparator_in, tx_serial_raw} = 2'b11;
        acc(1, 3'h6, 8'ha0);
        tick(2);
        chk("quiesce", 12'(quiesce_bits), 12'h003);
        chk("rx input", 12'(rx_serial), 12'h001);
        for (int p = 0; p < 8; p++) begin
            acc(1, 3'h7, 8'h08 | 8'(p));
            tick(2);
            chk("protocol", 12'(protocol_sel), 12'(p));
        end
        chk("tx invert", 12'(tx_serial_out), 12'h000);
        acc(1, 3'h7, 8'h80);
        tick(1);
        sys_rst = 1;
        tick(2);
        sys_rst = 0;
        tick(2);
        chk("soft reset", 12'(xcvr_reset), 12'h001);
    endtask
    // ==================================================================
    // Main sequence
    initial begin
        {sys_rst, cfg_rst, reg_wr, reg_rd, stall, send} = 6'b110000;
        {reg_addr, reg_wdata, word} = '0;
        {rx_err_parity, rx_err_ending, rx_err_midbit, rx_start} = '0;
        {rx_end, line_activity, tx_pre_start, tx_sending} = '0;
        {tx_serial_raw, serial_din, comparator_in} = '0;
        {err_count, checked, cycles} = '0;
        repeat (16) @(posedge sys_clk);
        #1;
        {sys_rst, cfg_rst} = 2'b00;
        chk("quiesce", 12'(quiesce_bits), 12'h002);
        t_tx();
        t_rx();
        t_link();
        t_mode();
        print_verdict();
    end
endmodule // transceiver_register_interface_tb_top
